// ---- design/ipc_link_core.sv ----
// ask packet receiver, fsk sender and phase sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ipc_defines.svh"
module ipc_link_core
    import ipc_pkg::*;
#(
    parameter int ASK_BIT_CYC = `IPC_ASK_BIT_NS / `IPC_CLK_NS
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        obj_placed,
    input  wire logic        ask_volt,
    input  wire logic        ask_curr,
    input  wire logic [7:0]  volt_quality,
    input  wire logic [7:0]  curr_quality,
    input  wire logic        fod_detected,
    input  wire logic        neg_grant_ok,
    input  wire logic        pwr_cycle,
    input  wire logic [15:0] fop_period,
    output logic             power_on,
    output logic [2:0]       phase,
    output logic             fsk_mod,
    output logic [15:0]      drive_period,
    output logic             curr_path_sel,
    output logic             pkt_valid,
    output logic [7:0]       pkt_header,
    output logic             ce_valid,
    output logic [7:0]       ce_value,
    output logic             rpp_valid,
    output logic [7:0]       rpp_value,
    output logic             ept_valid,
    output logic [7:0]       ept_code
);

    generate
        if (ASK_BIT_CYC < 8 || ASK_BIT_CYC > 30000) begin : g_chk
            $error("ASK_BIT_CYC out of range");
        end
    endgenerate

    ipc_core_t core_reg;   // registered state
    ipc_core_t core_next;  // next state
    logic      ask_sel;    // demod path fed to the decoder
    logic      dec_bit_v;  // decoded bit strobe
    logic      dec_bit;    // decoded bit value
    logic      dec_idle;   // no edges for two bit times

    // modulated or base level of one fsk half bit
    function automatic logic fsk_level(
        input logic [3:0] idx,
        input logic       b,
        input logic       second
    );
        // start bit is modulated both halves
        if (idx == 4'h0) begin
            return 1'b1;
        end
        // a one modulates only its second half
        return b & second;
    endfunction

    // packet header test, used by every phase after selection
    function automatic logic hdr_is(
        input logic [7:0] h,
        input logic [7:0] code
    );
        return h == code;
    endfunction

    // one decoder shared by both paths
    assign ask_sel = core_reg.sel_curr ? ask_curr : ask_volt;

    // coil signal demodulated into bits
    ipc_ask_bit_dec #(
        .BIT_CYC (ASK_BIT_CYC)
    ) u_dec (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .ask_in    (ask_sel),
        .bit_valid (dec_bit_v),
        .bit_value (dec_bit),
        .idle      (dec_idle)
    );

    // receive, sequence and send
    always_comb begin
        logic        pkt_ok;
        logic        fop_ok;
        logic [7:0]  hdr;
        logic [10:0] frame;
        pkt_ok = 1'b0;
        fop_ok = fop_period >= `IPC_MIN_PERIOD;
        hdr = core_reg.buf_b[0];
        frame = '0;
        core_next = core_reg;
        core_next.pkt_v = 1'b0;
        core_next.ce_v = 1'b0;
        core_next.rp_v = 1'b0;
        core_next.end_v = 1'b0;
        // presence of last cycle, so a placement is a rising level
        core_next.obj_prev = obj_placed;

        // path choice frozen while a packet arrives
        if (core_reg.rx == RX_HUNT && core_reg.nbytes == 4'h0 &&
            !core_reg.bad) begin
            core_next.sel_curr = curr_quality > volt_quality;
        end

        // byte assembly, 2 kbit/s bits
        if (dec_bit_v) begin
            unique case (core_reg.rx)
                RX_HUNT: begin
                    // preamble ones skipped, zero is start
                    if (!dec_bit) begin
                        core_next.rx = RX_BYTE;
                        core_next.bitn = 4'h0;
                    end
                end
                RX_BYTE: begin
                    // lsb first, then parity and stop
                    core_next.shift = {dec_bit, core_reg.shift[9:1]};
                    core_next.bitn = core_reg.bitn + 4'h1;
                    if (core_reg.bitn == 4'h9) begin
                        core_next.rx = RX_HUNT;
                        // odd parity and stop one keep it
                        if ((^core_next.shift[8:0]) &&
                            core_next.shift[9] &&
                            core_reg.nbytes < `IPC_MAX_BYTES) begin
                            core_next.buf_b[core_reg.nbytes[2:0]] =
                                core_next.shift[7:0];
                            core_next.xsum =
                                core_reg.xsum ^ core_next.shift[7:0];
                            core_next.nbytes = core_reg.nbytes + 4'h1;
                        end else begin
                            core_next.bad = 1'b1;
                        end
                    end
                end
            endcase
        end

        // silence closes the packet
        if (dec_idle && (core_reg.nbytes != 4'h0 || core_reg.bad ||
                         core_reg.rx == RX_BYTE)) begin
            // checksum folds to zero over all bytes
            pkt_ok = !core_reg.bad && core_reg.rx == RX_HUNT &&
                     core_reg.nbytes >= 4'h2 && core_reg.xsum == 8'h00;
            core_next.rx = RX_HUNT;
            core_next.nbytes = 4'h0;
            core_next.xsum = 8'h00;
            core_next.bad = 1'b0;
        end

        // a good packet opens the reply window
        if (pkt_ok) begin
            core_next.pkt_v = 1'b1;
            core_next.pkt_hdr = hdr;
            core_next.pkt_msg = core_reg.buf_b[1];
            core_next.tx_allow = 1'b1;
        end

        // phase sequencer
        unique case (core_reg.phase)
            PH_SELECT: begin
                // only a fresh placement starts a ping; an object left
                // lying after an end or a foreign object waits
                if (obj_placed && !core_reg.obj_prev) begin
                    core_next.phase = PH_PING;
                end
            end
            PH_PING: begin
                // power stays on into configuration
                if (pkt_ok && hdr_is(hdr, `IPC_HDR_SIG)) begin
                    core_next.phase = PH_IDCFG;
                end
            end
            PH_IDCFG: begin
                if (pkt_ok && hdr_is(hdr, `IPC_HDR_CFG)) begin
                    if (core_reg.buf_b[`IPC_NEG_BYTE][`IPC_NEG_BIT]) begin
                        core_next.phase = PH_NEGOT;
                    end else begin
                        // no reply for baseline profile
                        core_next.phase = PH_POWER;
                        core_next.tx_allow = 1'b0;
                    end
                end
            end
            PH_NEGOT: begin
                if (fod_detected) begin
                    core_next.phase = PH_SELECT;
                end else if (pkt_ok &&
                             hdr_is(hdr, `IPC_HDR_NEGREQ)) begin
                    // every request is answered, but no bit is modulated while fop_period is below IPC_MIN_PERIOD
                    core_next.tx_pend = 1'b1;
                    core_next.tx_data = neg_grant_ok ?
                        `IPC_RESP_GRANT : `IPC_RESP_DENY;
                end else if (pkt_ok &&
                             hdr_is(hdr, `IPC_HDR_CTRL)) begin
                    // control error ends negotiation
                    core_next.phase = PH_POWER;
                    core_next.ce_v = 1'b1;
                end
            end
            PH_POWER: begin
                // control, power and end packets
                if (pkt_ok && hdr_is(hdr, `IPC_HDR_CTRL)) begin
                    core_next.ce_v = 1'b1;
                end
                if (pkt_ok && hdr_is(hdr, `IPC_HDR_RPWR)) begin
                    core_next.rp_v = 1'b1;
                end
                if (pkt_ok && hdr_is(hdr, `IPC_HDR_END)) begin
                    core_next.end_v = 1'b1;
                    core_next.phase = PH_SELECT;
                end
            end
            default: begin
                // unused codes fall back to selection
                core_next.phase = PH_SELECT;
            end
        endcase

        // removal drops the link at once
        if (core_reg.phase != PH_SELECT && !obj_placed) begin
            core_next.phase = PH_SELECT;
        end
        if (core_next.phase == PH_SELECT) begin
            core_next.tx_pend = 1'b0;
            core_next.tx_allow = 1'b0;
        end

        // fsk byte sender, counted in power cycles
        unique case (core_reg.tx)
            TX_IDLE: begin
                // only inside a reply window
                if (core_reg.tx_pend && core_reg.tx_allow) begin
                    core_next.tx = TX_BITS;
                    core_next.tx_bit = 4'h0;
                    core_next.cyc = 10'h000;
                    core_next.tx_word = core_reg.tx_data;
                    core_next.tx_pend = 1'b0;
                    core_next.tx_allow = 1'b0;
                end
            end
            TX_BITS: begin
                if (pwr_cycle) begin
                    if (core_reg.cyc == `IPC_FSK_LAST) begin
                        core_next.cyc = 10'h000;
                        if (core_reg.tx_bit == `IPC_TX_LAST_BIT) begin
                            core_next.tx = TX_IDLE;
                        end else begin
                            core_next.tx_bit = core_reg.tx_bit + 4'h1;
                        end
                    end else begin
                        core_next.cyc = core_reg.cyc + 10'h001;
                    end
                end
            end
        endcase

        // stop one, odd parity, data, start
        frame = {1'b1, ~^core_next.tx_word, core_next.tx_word, 1'b0};
        // halves of 256 cycles; start, one, zero
        core_next.fsk_mod = core_next.tx == TX_BITS && fop_ok &&
            fsk_level(core_next.tx_bit, frame[core_next.tx_bit],
                      core_next.cyc >= `IPC_FSK_HALF);
        // modulated period three counts shorter
        core_next.period = core_next.fsk_mod ?
            fop_period - `IPC_MODULATED_OPERATING_FREQUENCY_SHORTEN : fop_period;
    end

    // state register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_next;
        end
    end

    // outputs
    assign power_on      = core_reg.phase != PH_SELECT;
    assign phase         = core_reg.phase;
    assign fsk_mod       = core_reg.fsk_mod;
    assign drive_period  = core_reg.period;
    assign curr_path_sel = core_reg.sel_curr;
    assign pkt_valid     = core_reg.pkt_v;
    assign pkt_header    = core_reg.pkt_hdr;
    assign ce_valid      = core_reg.ce_v;
    assign ce_value      = core_reg.pkt_msg;
    assign rpp_valid     = core_reg.rp_v;
    assign rpp_value     = core_reg.pkt_msg;
    assign ept_valid     = core_reg.end_v;
    assign ept_code      = core_reg.pkt_msg;

    a_modulated_operating_frequency_period: assert property (@(posedge clk_sys) disable iff (!nrst)
        fsk_mod |-> drive_period == $past(fop_period) - 16'h0003)
        else $error("modulated period not base minus three");

    a_dev_limit: assert property (@(posedge clk_sys) disable iff (!nrst)
        fsk_mod |-> $past(fop_period) > 16'h012c)
        else $error("deviation would reach one percent");

    a_tx_after_rx: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(core_reg.tx == TX_BITS) |-> $past(core_reg.tx_allow))
        else $error("fsk started without a received packet");

    a_start_mod: assert property (@(posedge clk_sys) disable iff (!nrst)
        (core_reg.tx == TX_BITS && core_reg.tx_bit == 4'h0 &&
         $past(fop_period) > 16'h012c) |-> fsk_mod)
        else $error("start bit not modulated");

    a_zero_base: assert property (@(posedge clk_sys) disable iff (!nrst)
        (core_reg.tx == TX_BITS && core_reg.tx_bit != 4'h0 &&
         core_reg.cyc < 10'h100) |-> !fsk_mod)
        else $error("first half of a data bit modulated");

    a_sel_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        (phase == PH_SELECT && !obj_placed) |=> phase == PH_SELECT)
        else $error("left selection without placement");

    a_neg_exit: assert property (@(posedge clk_sys) disable iff (!nrst)
        (phase == PH_NEGOT && fod_detected) |=> phase == PH_SELECT)
        else $error("foreign object ignored in negotiation");

    a_end_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
        ept_valid |-> !power_on ##1 !power_on)
        else $error("power kept after end transfer packet");

    a_ce_power: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce_valid |-> phase == PH_POWER && pkt_valid)
        else $error("control error outside power transfer");

    a_noneg_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
        ($past(phase) == PH_IDCFG && phase == PH_POWER)
        |-> !core_reg.tx_pend [*4])
        else $error("reply queued for baseline configuration");

endmodule
`default_nettype wire

// ---- design/ipc_defines.svh ----
// constants of the inductive link modem and phase control
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH
// Functional notes
// - receiver ask bits at 2 kbit/s recovered
// - packets come from coil current or voltage
// - one decoder, better demod path chosen
// - fsk shifts frequency in 256-cycle units
// - modulated period is base minus 3 counts
// - send only after rx packet, deviation under 1%
// - start bit is 512 modulated cycles
// - one bit: 256 base then 256 modulated
// - zero bit: 512 base cycles
// - byte framed start, data, parity, stop
// - bi-phase decode: two narrow or one wide
// - rx byte is 11 bits
// - packet: preamble, header, message, checksum
// - selection waits for object placement
// - signal strength packet moves ping to config
// - neg bit clear: power transfer, no reply
// - neg bit set: enter negotiation
// - each negotiation request granted or denied
// - foreign object in negotiation: back to select
// - power phase handles control, power, end packets
// - end transfer packet stops power

// timing
`define IPC_CLK_NS       100
`define IPC_ASK_BIT_NS   500000
`define IPC_FSK_HALF     10'h100
`define IPC_FSK_LAST     10'h1ff
`define IPC_TX_LAST_BIT  4'ha
// modulated period shortening in 60 MHz counts
`define IPC_MODULATED_OPERATING_FREQUENCY_SHORTEN 16'h0003
// below 301 counts three counts reach 1 %
`define IPC_MIN_PERIOD   16'h012d
// packet headers
`define IPC_HDR_SIG      8'h01
`define IPC_HDR_END      8'h02
`define IPC_HDR_CTRL     8'h03
`define IPC_HDR_RPWR     8'h04
`define IPC_HDR_NEGREQ   8'h20
`define IPC_HDR_CFG      8'h51
// negotiation request flag inside configuration
`define IPC_NEG_BYTE     3'h3
`define IPC_NEG_BIT      3'h7
// negotiation answers
`define IPC_RESP_GRANT   8'hff
`define IPC_RESP_DENY    8'h00
// receive buffer depth in bytes
`define IPC_MAX_BYTES    4'h8
`endif

// ---- design/ipc_pkg.sv ----
// types of the inductive link modem and phase control
package ipc_pkg;

    // power transfer phases
    typedef enum logic [2:0] {
        PH_SELECT = 3'h0,
        PH_PING   = 3'h1,
        PH_IDCFG  = 3'h2,
        PH_NEGOT  = 3'h3,
        PH_POWER  = 3'h4
    } ipc_phase_t;

    // byte receiver
    typedef enum logic {
        RX_HUNT = 1'h0,
        RX_BYTE = 1'h1
    } ipc_rx_t;

    // fsk byte sender
    typedef enum logic {
        TX_IDLE = 1'h0,
        TX_BITS = 1'h1
    } ipc_tx_t;

    // bi-phase bit decoder state
    typedef struct packed {
        logic        prev;
        logic        sync;
        logic        half;
        logic        bit_v;
        logic        bit_d;
        logic [15:0] cnt;
    } ipc_dec_t;

    // core state
    typedef struct packed {
        ipc_phase_t      phase;
        logic            obj_prev;
        logic            sel_curr;
        ipc_rx_t         rx;
        logic [3:0]      bitn;
        logic [9:0]      shift;
        logic [3:0]      nbytes;
        logic [7:0][7:0] buf_b;
        logic [7:0]      xsum;
        logic            bad;
        ipc_tx_t         tx;
        logic [3:0]      tx_bit;
        logic [9:0]      cyc;
        logic [7:0]      tx_word;
        logic            tx_pend;
        logic [7:0]      tx_data;
        logic            tx_allow;
        logic            fsk_mod;
        logic [15:0]     period;
        logic            pkt_v;
        logic [7:0]      pkt_hdr;
        logic [7:0]      pkt_msg;
        logic            ce_v;
        logic            rp_v;
        logic            end_v;
    } ipc_core_t;

endpackage

// ---- design/ipc_ask_bit_dec.sv ----
// differential bi-phase bit decoder for the receiver's ask signal
`timescale 1ns/1ps
`default_nettype none
module ipc_ask_bit_dec
    import ipc_pkg::*;
#(
    parameter int BIT_CYC = 5000
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic ask_in,
    output logic      bit_valid,
    output logic      bit_value,
    output logic      idle
);

    // gap below three quarters of a bit is a half
    localparam logic [15:0] SHORT_CYC = 16'(BIT_CYC * 3 / 4);
    // two bit times without an edge end the packet
    localparam logic [15:0] IDLE_CYC  = 16'(BIT_CYC * 2);

    generate
        if (BIT_CYC < 8 || BIT_CYC > 30000) begin : g_chk
            $error("BIT_CYC out of range");
        end
    endgenerate

    ipc_dec_t dec_reg;   // registered state
    ipc_dec_t dec_next;  // next state

    // edge spacing decides the bit
    always_comb begin
        dec_next = dec_reg;
        dec_next.bit_v = 1'b0;
        dec_next.prev = ask_in;
        if (ask_in != dec_reg.prev) begin
            dec_next.cnt = 16'h0000;
            if (!dec_reg.sync) begin
                // first edge after silence only aligns
                dec_next.sync = 1'b1;
                dec_next.half = 1'b0;
            end else if (dec_reg.cnt < SHORT_CYC) begin
                // two narrow halves make a one
                if (dec_reg.half) begin
                    dec_next.bit_v = 1'b1;
                    dec_next.bit_d = 1'b1;
                    dec_next.half = 1'b0;
                end else begin
                    dec_next.half = 1'b1;
                end
            end else begin
                // one wide gap is a zero
                dec_next.bit_v = 1'b1;
                dec_next.bit_d = 1'b0;
                dec_next.half = 1'b0;
            end
        end else if (dec_reg.cnt >= IDLE_CYC) begin
            dec_next.sync = 1'b0;
        end else begin
            dec_next.cnt = dec_reg.cnt + 16'h0001;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dec_reg <= '0;
        end else begin
            dec_reg <= dec_next;
        end
    end

    assign bit_valid = dec_reg.bit_v;
    assign bit_value = dec_reg.bit_d;
    assign idle      = !dec_reg.sync;

    a_wide_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        (bit_valid && !bit_value) |-> $past(dec_reg.cnt) >= SHORT_CYC)
        else $error("zero decoded from a narrow gap");

endmodule
`default_nettype wire

// ---- tb/ipc_rx_model.sv ----
// receiver side model: ask packet sender and fsk listener
`timescale 1ns/1ps
`default_nettype none
module ipc_rx_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic clk_sys,
    input  wire logic fsk_mod,
    output var logic  ask,
    output var logic  pwr_cycle
);
    initial ask = 1'b0;
    initial pwr_cycle = 1'b0;
    // a pulse every second clock stands in for the power signal
    always @(posedge clk_sys) begin
        pwr_cycle <= ~pwr_cycle;
    end
    // half bit: toggle the load level when asked, then hold it
    task automatic half(input logic t);
        ask <= ask ^ t;
        repeat (BIT_CYC / 2) @(posedge clk_sys);
    endtask
    // bi-phase: edge at each boundary, extra mid edge for a one
    task automatic send_bit(input logic b);
        half(1'b1);
        half(b);
    endtask
    task automatic send_byte(input logic [7:0] d, input logic bad);
        send_bit(1'b0);
        for (int i = 0; i < 8; i++) send_bit(d[i]);
        send_bit(~^d ^ bad);
        send_bit(1'b1);
    endtask
    // bad[1] spoils the header parity, bad[0] the checksum
    task automatic send_pkt(input logic [7:0] h, input logic [31:0] m,
                            input int n, input logic [1:0] bad);
        logic [7:0] x;
        x = h;
        @(posedge clk_sys);
        repeat (4) send_bit(1'b1);
        send_byte(h, bad[1]);
        for (int i = 0; i < n; i++) begin
            send_byte(m[8*i+:8], 1'b0);
            x = x ^ m[8*i+:8];
        end
        send_byte(x ^ {7'h00, bad[0]}, 1'b0);
        half(1'b1); // closing boundary, then silence ends the packet
    endtask
    // sample each 256 cycle half in its middle, so drift is harmless
    task automatic recv(output logic [21:0] hv);
        for (int k = 0; k < 22; k++) begin
            for (int p = 0; p < 256; p++) begin
                @(posedge clk_sys iff pwr_cycle);
                if (p == 128) hv[k] = fsk_mod;
            end
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/test_inductive_link_modem_and_phase_control.sv ----
// self-checking bench of the link core against a receiver model
`timescale 1ns/1ps
`default_nettype none
module test_inductive_link_modem_and_phase_control;
    import ipc_pkg::*;
    localparam int BC = 16; // short ask bit keeps the run brief
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        obj_placed = 1'b0;
    logic        use_curr = 1'b0;
    logic        fod_detected = 1'b0;
    logic        neg_grant_ok = 1'b0;
    logic [7:0]  volt_quality = 8'h40;
    logic [7:0]  curr_quality = 8'h10;
    logic [15:0] fop_period = 16'h01f4;
    logic        ask, pwr_cycle, fsk_mod, power_on, curr_path_sel;
    logic        pkt_valid, ce_valid, rpp_valid, ept_valid, pw;
    logic [2:0]  phase, flg, ph;
    logic [7:0]  pkt_header, ce_value, rpp_value, ept_code, hd, val;
    logic [15:0] drive_period;
    int          n_pkt = 0, n_mod = 0, mismatches = 0, n_compared = 0;
    // the ask line reaches only the path under test
    wire logic   ask_volt = use_curr ? 1'b0 : ask;
    wire logic   ask_curr = use_curr ? ask : 1'b0;

    always #50 clk_sys = ~clk_sys; // 10 MHz

    ipc_link_core #(.ASK_BIT_CYC(BC)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .obj_placed(obj_placed),
        .ask_volt(ask_volt), .ask_curr(ask_curr),
        .volt_quality(volt_quality), .curr_quality(curr_quality),
        .fod_detected(fod_detected), .neg_grant_ok(neg_grant_ok),
        .pwr_cycle(pwr_cycle), .fop_period(fop_period),
        .power_on(power_on), .phase(phase), .fsk_mod(fsk_mod),
        .drive_period(drive_period), .curr_path_sel(curr_path_sel),
        .pkt_valid(pkt_valid), .pkt_header(pkt_header),
        .ce_valid(ce_valid), .ce_value(ce_value), .rpp_valid(rpp_valid),
        .rpp_value(rpp_value), .ept_valid(ept_valid), .ept_code(ept_code));
    ipc_rx_model #(.BIT_CYC(BC)) rx (.clk_sys(clk_sys), .fsk_mod(fsk_mod),
                                     .ask(ask), .pwr_cycle(pwr_cycle));

    // note each packet pulse with what stood beside it in that cycle
    always @(posedge clk_sys) begin
        if (fsk_mod === 1'b1) n_mod++;
        if (pkt_valid === 1'b1) begin
            n_pkt++;
            hd = pkt_header;
            flg = {ce_valid, rpp_valid, ept_valid};
            val = ce_valid ? ce_value : (rpp_valid ? rpp_value : ept_code);
            ph = phase;
            pw = power_on;
        end
    end

    task automatic chk(input string nm, input logic [21:0] e, g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // wait edges, then let their updates land
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // send one packet; a spoiled one must bring no pulse at all
    task automatic pkt(input logic [7:0] h, input logic [31:0] m, input int n,
                       input logic [1:0] bad, input logic [2:0] ef);
        int c0;
        c0 = n_pkt;
        rx.send_pkt(h, m, n, bad);
        for (int k = 0; k < 4 * BC && n_pkt == c0; k++) @(posedge clk_sys);
        tick(1);
        chk("packet count", 22'(bad == 2'b00), 22'(n_pkt - c0));
        if (bad == 2'b00) begin
            chk("header", 22'(h), 22'(hd));
            chk("kind flags", 22'(ef), 22'(flg));
        end
    endtask
    // halves of a reply: start all modulated, then base and bit value
    function automatic logic [21:0] frame(input logic [7:0] d);
        logic [10:0] w;
        logic [21:0] f;
        w = {1'b1, ~^d, d, 1'b0};
        f = 22'h000003;
        for (int i = 1; i < 11; i++) f[2*i+1] = w[i];
        return f;
    endfunction

    task automatic t_select();
        tick(4);
        chk("phase", 22'(3'h0), 22'(phase));
        chk("power", 22'(1'b0), 22'(power_on));
        @(posedge clk_sys);
        obj_placed <= 1'b1;
        tick(2);
        chk("phase", 22'(3'h1), 22'(phase));
    endtask
    task automatic t_ping();
        pkt(8'h01, 32'h40, 1, 2'b01, 3'b000);
        pkt(8'h01, 32'h40, 1, 2'b10, 3'b000);
        chk("phase", 22'(3'h1), 22'(phase));
        pkt(8'h01, 32'h40, 1, 2'b00, 3'b000);
        chk("phase", 22'(3'h2), 22'(phase));
        chk("power", 22'(1'b1), 22'(power_on));
    endtask
    // grant then deny, each answered by a full frame; then a foreign object
    task automatic t_negot();
        logic [21:0] hv;
        int          m0;
        pkt(8'h51, 32'h0080_0000, 3, 2'b00, 3'b000);
        chk("phase", 22'(3'h3), 22'(phase));
        for (int g = 1; g >= 0; g--) begin
            @(posedge clk_sys);
            neg_grant_ok <= g[0];
            pkt(8'h20, 32'h1, 1, 2'b00, 3'b000);
            for (int k = 0; k < 8 && fsk_mod !== 1'b1; k++) tick(1);
            chk("mod period", 22'(fop_period - 16'h0003),
                22'(drive_period));
            rx.recv(hv);
            chk("reply", frame(g ? 8'hff : 8'h00), hv);
            tick(8);
            chk("base period", 22'(fop_period), 22'(drive_period));
        end
        // a base period of 300 counts leaves no room below 1 %
        @(posedge clk_sys);
        fop_period <= 16'h012c;
        m0 = n_mod;
        pkt(8'h20, 32'h1, 1, 2'b00, 3'b000);
        tick(11400); // a whole frame time passes unmodulated
        chk("fsk at 300", 22'h0, 22'(n_mod - m0));
        chk("period", 22'(16'h012c), 22'(drive_period));
        @(posedge clk_sys);
        fop_period <= 16'h01f4;
        fod_detected <= 1'b1;
        tick(1);
        chk("phase", 22'(3'h0), 22'(phase));
        @(posedge clk_sys);
        fod_detected <= 1'b0;
        tick(3); // object still lying there is no new placement
        chk("phase", 22'(3'h0), 22'(phase));
    endtask
    // current path wins on quality; baseline contract, then power packets
    task automatic t_power();
        int m0;
        @(posedge clk_sys);
        use_curr <= 1'b1;
        curr_quality <= 8'h80;
        obj_placed <= 1'b0;
        tick(3 * BC); // let the switch glitch end in silence
        @(posedge clk_sys);
        obj_placed <= 1'b1; // placed anew, so a ping follows
        pkt(8'h01, 32'h40, 1, 2'b00, 3'b000);
        chk("path", 22'(1'b1), 22'(curr_path_sel));
        m0 = n_mod;
        pkt(8'h51, 32'h0, 3, 2'b00, 3'b000);
        chk("phase", 22'(3'h4), 22'(phase));
        pkt(8'h03, 32'h11, 1, 2'b00, 3'b100);
        chk("value", 22'(8'h11), 22'(val));
        pkt(8'h04, 32'h22, 1, 2'b00, 3'b010);
        chk("value", 22'(8'h22), 22'(val));
        chk("fsk silent", 22'h0, 22'(n_mod - m0));
        pkt(8'h02, 32'h33, 1, 2'b00, 3'b001);
        chk("value", 22'(8'h33), 22'(val));
        chk("stop phase", 22'(3'h0), 22'(ph));
        chk("stop power", 22'(1'b0), 22'(pw));
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        t_select();
        t_ping();
        t_negot();
        t_power();
        complete_run();
    end
    // tests need about 42k cycles; give up at 80k
    initial begin
        #8_000_000;
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
